//--- logic/cxt_alu.sv
/*
 Combinational arithmetic unit: subtract, borrow subtract, swap, xor.
 Assumes operands arrive stable from the execute stage.
*/
`timescale 1ns/1ps
module cxt_alu (
   input  wire cxt_pkg::cxt_op_t op,        // Operation select
   input  wire logic [7:0]       file_val,  // Minuend / file operand
   input  wire logic [7:0]       work_val,  // Working register
   input  wire logic [7:0]       imm_val,   // Immediate literal
   input  wire logic             carry_in,  // Current carry flag
   output logic      [7:0]       result,    // Result byte
   output logic                  carry_out, // New carry
   output logic                  digit_out, // New digit carry
   output logic                  zero_out   // New zero flag
);

   logic [8:0] diff;  // Nine-bit difference, top bit is borrow
   logic [4:0] ndiff; // Low nibble difference
   logic       bin;   // Pending borrow

   // Arithmetic selection
   always_comb begin
      bin   = 1'b0;
      diff  = 9'h000;
      ndiff = 5'h00;
      result = 8'h00;
      if (op == cxt_pkg::cxt_op_sub_with_borrow_op) begin
         bin = ~carry_in;
      end
      case (op)
         cxt_pkg::cxt_op_sub_work_from_file_op,
         cxt_pkg::cxt_op_sub_with_borrow_op: begin
            diff  = {1'b0, file_val} - {1'b0, work_val} - {8'h00, bin};
            ndiff = {1'b0, file_val[3:0]} - {1'b0, work_val[3:0]}
                    - {4'h0, bin};
            result = diff[7:0];
         end
         cxt_pkg::cxt_op_nibble_exchange_op: begin
            result = {file_val[3:0], file_val[7:4]};
         end
         cxt_pkg::cxt_op_xor_immediate_op: begin
            result = work_val ^ imm_val;
         end
         cxt_pkg::cxt_op_xor_file_op: begin
            result = work_val ^ file_val;
         end
         default: begin
            result = work_val;
         end
      endcase
   end

   // Borrow shows as carry clear
   assign carry_out = ~diff[8];
   assign digit_out = ~ndiff[4];
   assign zero_out  = (result == 8'h00);

endmodule : cxt_alu

//--- logic/cxt_exec.sv
/*
 Execute stage for the tail group of instructions: sleep, subtract,
 borrow subtract, nibble swap, xor immediate/file, direction load.
 Assumes the decoder gives one op per cycle with exec_valid, the file
 operand already read, and a file write port that accepts one cycle
 write strobes. Ops are ignored while halted.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cxt_exec (
   input  wire logic             mclk,         // Core clock 125 MHz
   input  wire logic             nrst,         // Sync reset, active low
   input  wire logic             exec_valid,   // Op presented this cycle
   input  wire cxt_pkg::cxt_op_t exec_op,      // Operation
   input  wire logic [6:0]       file_addr,    // Bank offset of operand
   input  wire logic             dest_sel,     // Destination bit
   input  wire logic [7:0]       file_rdata,   // Operand file value
   input  wire logic [7:0]       imm_val,      // Immediate literal
   input  wire logic             wake,         // Wake event
   input  wire logic             wdt_ack,      // Unused spare ack
   output logic      [7:0]       work_reg,     // Working register
   output logic                  carry_flag,   // Carry
   output logic                  digit_carry_flag, // Digit carry
   output logic                  zero_flag,    // Zero
   output logic                  power_down_flag,  // Active low style
   output logic                  timeout_flag, // Time-out status
   output logic      [7:0]       port_a_direction, // Port A dir
   output logic      [7:0]       port_b_direction, // Port B dir
   output logic      [7:0]       port_c_direction, // Port C dir
   output logic                  file_we,      // File write strobe
   output logic      [6:0]       file_waddr,   // File write address
   output logic      [7:0]       file_wdata,   // File write data
   output logic                  wdt_clear,    // Watchdog clear pulse
   output logic      [7:0]       watchdog_counter, // Watchdog count
   output logic      [7:0]       wdt_prescale, // Prescaler count
   output logic                  halted,       // Core halted
   output logic                  osc_run,      // Oscillator enable
   output logic                  bad_operand   // Invalid direction op
);

   logic [7:0] alu_res;   // Result byte
   logic       alu_c;     // Carry from unit
   logic       alu_dc;    // Digit carry from unit
   logic       alu_z;     // Zero from unit
   logic       go;        // Op accepted this cycle
   logic       is_sub;    // Subtract family
   logic       to_file;   // Result goes to file

   // Only act while the core runs
   assign go = exec_valid && !halted;
   assign is_sub = (exec_op == cxt_pkg::cxt_op_sub_work_from_file_op) ||
                   (exec_op == cxt_pkg::cxt_op_sub_with_borrow_op);

   // Direction loads and xor immediate never write the file
   function automatic logic routes_dest(input cxt_pkg::cxt_op_t o);
      routes_dest = (o == cxt_pkg::cxt_op_sub_work_from_file_op) ||
                    (o == cxt_pkg::cxt_op_sub_with_borrow_op) ||
                    (o == cxt_pkg::cxt_op_nibble_exchange_op) ||
                    (o == cxt_pkg::cxt_op_xor_file_op);
   endfunction : routes_dest

   assign to_file = routes_dest(exec_op) &&
                    (dest_sel == cxt_pkg::DEST_FILE);

   cxt_alu u_alu (
      .op        (exec_op),
      .file_val  (file_rdata),
      .work_val  (work_reg),
      .imm_val   (imm_val),
      .carry_in  (carry_flag),
      .result    (alu_res),
      .carry_out (alu_c),
      .digit_out (alu_dc),
      .zero_out  (alu_z)
   );

   cxt_sleep u_sleep (
      .mclk    (mclk),
      .nrst    (nrst),
      .enter   (go && exec_op == cxt_pkg::cxt_op_sleep),
      .wake    (wake),
      .halted  (halted),
      .osc_run (osc_run)
   );

   // Working register update
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         work_reg <= cxt_pkg::WORK_RESET;
      end else if (go) begin
         if (exec_op == cxt_pkg::cxt_op_xor_immediate_op) begin
            work_reg <= alu_res;
         end else if (routes_dest(exec_op) &&
                      dest_sel == cxt_pkg::DEST_WORK) begin
            work_reg <= alu_res;
         end
      end
   end

   // File write port, one cycle strobe; address is a bank offset
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         file_we    <= 1'b0;
         file_waddr <= 7'h00;
         file_wdata <= 8'h00;
      end else begin
         file_we <= go && to_file;
         if (go && to_file) begin
            file_waddr <= file_addr;
            file_wdata <= alu_res;
         end
      end
   end

   // Arithmetic flags; swap and direction load leave them alone
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         carry_flag       <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero_flag        <= 1'b0;
      end else if (go) begin
         if (is_sub) begin
            carry_flag       <= alu_c;
            digit_carry_flag <= alu_dc;
            zero_flag        <= alu_z;
         end else if (exec_op == cxt_pkg::cxt_op_xor_immediate_op ||
                      exec_op == cxt_pkg::cxt_op_xor_file_op) begin
            zero_flag <= alu_z;
         end
      end
   end

   // Power status flags: sleep clears power-down and sets time-out
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         power_down_flag <= cxt_pkg::STAT_RESET[cxt_pkg::STAT_PDOWN];
         timeout_flag    <= cxt_pkg::STAT_RESET[cxt_pkg::STAT_TIMEOUT];
      end else if (go && exec_op == cxt_pkg::cxt_op_sleep) begin
         power_down_flag <= 1'b0;
         timeout_flag    <= 1'b1;
      end
   end

   // Watchdog and prescaler: free count, cleared by sleep.
   // The count runs on mclk here; a real core would use the LF clock.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wdt_prescale     <= cxt_pkg::PRE_CLEAR;
         watchdog_counter <= cxt_pkg::WDT_CLEAR;
         wdt_clear        <= 1'b0;
      end else begin
         wdt_clear <= go && exec_op == cxt_pkg::cxt_op_sleep;
         if (go && exec_op == cxt_pkg::cxt_op_sleep) begin
            wdt_prescale     <= cxt_pkg::PRE_CLEAR;
            watchdog_counter <= cxt_pkg::WDT_CLEAR;
         end else begin
            wdt_prescale <= wdt_prescale + 8'h01;
            if (wdt_prescale == 8'hFF) begin
               watchdog_counter <= watchdog_counter + 8'h01;
            end
         end
      end
   end

   // Direction registers; bad operands load nothing and flag it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         port_a_direction <= cxt_pkg::DIR_RESET;
         port_b_direction <= cxt_pkg::DIR_RESET;
         port_c_direction <= cxt_pkg::DIR_RESET;
         bad_operand      <= 1'b0;
      end else begin
         bad_operand <= 1'b0;
         if (go && exec_op == cxt_pkg::cxt_op_direction_load_op) begin
            case (file_addr)
               cxt_pkg::DIR_PORT_A: port_a_direction <= work_reg;
               cxt_pkg::DIR_PORT_B: port_b_direction <= work_reg;
               cxt_pkg::DIR_PORT_C: port_c_direction <= work_reg;
               default:             bad_operand      <= 1'b1;
            endcase
         end
      end
   end

endmodule : cxt_exec

//--- logic/cxt_pkg.sv
/*
 Package for the instruction execution tail of an 8-bit core.
 Holds operation codes, register offsets, field positions, reset values
 and the sleep state encoding. Assumes a single 125 MHz core clock.
*/
// Behaviour
// - Sleep halts the core until wake
// - Sleep clears power-down, sets time-out flag
// - Sleep clears watchdog counter and prescaler
// - Oscillator stopped while asleep
// - Subtract: file minus work to destination
// - Borrow subtract: file minus work minus not-carry
// - Borrow subtract: d=0 work, d=1 file
// - Swap nibbles, flags untouched
// - Xor immediate into work, zero flag only
// - Xor file with work, zero flag only
// - Xor file: d=0 work, d=1 file
// - Direction load copies work, flags untouched
// - Operand 5,6,7 selects port A,B,C
// - Carry clear when subtrahend exceeds minuend
package cxt_pkg;

   // Operation select presented by the decoder
   typedef enum logic [2:0] {
      cxt_op_none           = 3'h0,
      cxt_op_sleep          = 3'h1,
      cxt_op_sub_work_from_file_op = 3'h2,
      cxt_op_sub_with_borrow_op    = 3'h3,
      cxt_op_nibble_exchange_op    = 3'h4,
      cxt_op_xor_immediate_op      = 3'h5,
      cxt_op_xor_file_op           = 3'h6,
      cxt_op_direction_load_op     = 3'h7
   } cxt_op_t;

   // Core run state; one bit changes per step except wake to run
   typedef enum logic [1:0] {
      cxt_st_run   = 2'b00,
      cxt_st_sleep = 2'b01,
      cxt_st_wake  = 2'b11
   } cxt_state_t;

   // Destination bit values
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // Direction load operands
   localparam logic [6:0] DIR_PORT_A = 7'h05;
   localparam logic [6:0] DIR_PORT_B = 7'h06;
   localparam logic [6:0] DIR_PORT_C = 7'h07;

   // Status field positions
   localparam int STAT_CARRY   = 0;
   localparam int STAT_DIGIT   = 1;
   localparam int STAT_ZERO    = 2;
   localparam int STAT_PDOWN   = 3;
   localparam int STAT_TIMEOUT = 4;

   // Reset values
   localparam logic [7:0] WORK_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET  = 8'hFF;
   localparam logic [4:0] STAT_RESET = 5'h18;
   localparam logic [7:0] WDT_CLEAR  = 8'h00;
   localparam logic [7:0] PRE_CLEAR  = 8'h00;

endpackage : cxt_pkg

//--- logic/cxt_sleep.sv
/*
 Sleep controller: holds the core halted and the oscillator gated off
 from a sleep instruction until a wake event. Single clock domain.
*/
`timescale 1ns/1ps
module cxt_sleep (
   input  wire logic mclk,      // Core clock
   input  wire logic nrst,      // Synchronous reset, active low
   input  wire logic enter,     // Sleep instruction executes
   input  wire logic wake,      // Wake-up event level
   output logic      halted,    // Core halted
   output logic      osc_run    // Oscillator enable
);

   cxt_pkg::cxt_state_t state; // Current run state

   // Run/sleep sequencing; wake takes one cycle to restart fetch
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state <= cxt_pkg::cxt_st_run;
      end else begin
         case (state)
            cxt_pkg::cxt_st_run: begin
               if (enter) state <= cxt_pkg::cxt_st_sleep;
            end
            cxt_pkg::cxt_st_sleep: begin
               if (wake) state <= cxt_pkg::cxt_st_wake;
            end
            cxt_pkg::cxt_st_wake: begin
               state <= cxt_pkg::cxt_st_run;
            end
            default: begin
               state <= cxt_pkg::cxt_st_run;
            end
         endcase
      end
   end

   // Halt covers sleep and the restart cycle
   assign halted  = (state != cxt_pkg::cxt_st_run);
   assign osc_run = (state != cxt_pkg::cxt_st_sleep);

endmodule : cxt_sleep

//--- sim/cxt_exec_sva.sv
/*
 Checker for the cxt_exec ports, bound to every instance below.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module cxt_exec_chk (
   input wire logic             mclk,
   input wire logic             nrst,
   input wire logic             exec_valid,
   input wire cxt_pkg::cxt_op_t exec_op,
   input wire logic [6:0]       file_addr,
   input wire logic             dest_sel,
   input wire logic [7:0]       file_rdata,
   input wire logic [7:0]       imm_val,
   input wire logic [7:0]       work_reg,
   input wire logic             carry_flag,
   input wire logic             digit_carry_flag,
   input wire logic             zero_flag,
   input wire logic             power_down_flag,
   input wire logic             timeout_flag,
   input wire logic             file_we,
   input wire logic [6:0]       file_waddr,
   input wire logic [7:0]       file_wdata,
   input wire logic [7:0]       watchdog_counter,
   input wire logic [7:0]       wdt_prescale,
   input wire logic             halted,
   input wire logic             osc_run
);
   // An op counts only when not halted; dropped ops must leave no trace
   wire       take = exec_valid && !halted;
   wire       slp  = take && exec_op == cxt_pkg::cxt_op_sleep;
   wire       sub  = take && exec_op == cxt_pkg::cxt_op_sub_work_from_file_op;
   wire       subb = take && exec_op == cxt_pkg::cxt_op_sub_with_borrow_op;
   wire       swp  = take && exec_op == cxt_pkg::cxt_op_nibble_exchange_op;
   wire       xim  = take && exec_op == cxt_pkg::cxt_op_xor_immediate_op;
   wire       xfo  = take && exec_op == cxt_pkg::cxt_op_xor_file_op;
   wire [3:0] f_lo = file_rdata[3:0];  // Nibbles, so $past sees a signal
   wire [3:0] f_hi = file_rdata[7:4];
   wire [3:0] w_lo = work_reg[3:0];
   wire [2:0] flg  = {carry_flag, digit_carry_flag, zero_flag};

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_sleep_halt:
      assert property (slp |=> halted && !osc_run)
      else $error("sleep did not halt the core");
   chk_halt_ignore:
      assert property (halted |=> $stable(work_reg) && !file_we)
      else $error("op acted while halted");
   chk_sleep_flags:
      assert property (slp |=> !power_down_flag && timeout_flag)
      else $error("sleep status flags wrong");
   chk_sleep_wdt:
      assert property (slp |=> watchdog_counter == 8'h00
         && wdt_prescale == 8'h00)
      else $error("watchdog not cleared by sleep");
   chk_osc_stop:
      assert property (!osc_run |-> halted)
      else $error("oscillator stopped while running");
   chk_sub_dest:
      assert property (sub && dest_sel |=> file_we
         && file_waddr == $past(file_addr)
         && file_wdata == $past(file_rdata) - $past(work_reg))
      else $error("subtract file write wrong");
   chk_sub_flags:
      assert property (sub |=>
         carry_flag == ($past(file_rdata) >= $past(work_reg))
         && digit_carry_flag == ($past(f_lo) >= $past(w_lo))
         && zero_flag == ($past(file_rdata) == $past(work_reg)))
      else $error("subtract flags wrong");
   chk_subb_data:
      assert property (subb && dest_sel |=> file_we && file_wdata ==
         $past(file_rdata) - $past(work_reg) - {7'h00, !$past(carry_flag)})
      else $error("borrow subtract result wrong");
   chk_swap_keep:
      assert property (swp |=> $stable(flg) &&
         (file_we ? file_wdata : work_reg) == {$past(f_lo), $past(f_hi)})
      else $error("nibble swap wrong");
   chk_xor_imm:
      assert property (xim |=> work_reg == ($past(work_reg) ^ $past(imm_val))
         && zero_flag == ($past(work_reg) == $past(imm_val)) && !file_we)
      else $error("xor immediate wrong");
   chk_xor_file:
      assert property (xfo |=> file_we == $past(dest_sel)
         && (file_we ? file_wdata : work_reg) ==
            ($past(work_reg) ^ $past(file_rdata))
         && zero_flag == ($past(work_reg) == $past(file_rdata))
         && $stable(carry_flag) && $stable(digit_carry_flag))
      else $error("xor file wrong");
endmodule : cxt_exec_chk

bind cxt_exec cxt_exec_chk i_chk (.mclk, .nrst, .exec_valid, .exec_op,
   .file_addr, .dest_sel, .file_rdata, .imm_val, .work_reg, .carry_flag,
   .digit_carry_flag, .zero_flag, .power_down_flag, .timeout_flag, .file_we,
   .file_waddr, .file_wdata, .watchdog_counter, .wdt_prescale, .halted,
   .osc_run);

//--- sim/testbench.sv
/*
 Self-checking bench for cxt_exec: a model of W, flags and direction
 registers judges every op. Assumes cxt_pkg is compiled first.
*/
`timescale 1ns/1ps
module testbench;
   typedef cxt_pkg::cxt_op_t cxt_tb_op_t;  // Short alias for the op tables
   localparam cxt_tb_op_t op_sub  = cxt_pkg::cxt_op_sub_work_from_file_op;
   localparam cxt_tb_op_t op_subb = cxt_pkg::cxt_op_sub_with_borrow_op;
   localparam cxt_tb_op_t op_swap = cxt_pkg::cxt_op_nibble_exchange_op;
   localparam cxt_tb_op_t op_xi   = cxt_pkg::cxt_op_xor_immediate_op;
   localparam cxt_tb_op_t op_xf   = cxt_pkg::cxt_op_xor_file_op;
   localparam cxt_tb_op_t op_dir  = cxt_pkg::cxt_op_direction_load_op;
   logic             mclk = 1'b0;        // 125 MHz core clock
   logic             nrst = 1'b0;        // Sync reset, active low
   logic             exec_valid = 1'b0;  // Op strobe
   cxt_tb_op_t       exec_op = cxt_pkg::cxt_op_none;
   logic [6:0]       file_addr = 7'h00;
   logic             dest_sel = 1'b0;
   logic [7:0]       file_rdata = 8'h00;
   logic [7:0]       imm_val = 8'h00;
   logic             wake = 1'b0;        // Wake level
   logic [7:0]       work_reg, file_wdata, watchdog_counter, wdt_prescale;
   logic [7:0]       port_a_direction, port_b_direction, port_c_direction;
   logic [6:0]       file_waddr;
   logic             carry_flag, digit_carry_flag, zero_flag, file_we;
   logic             power_down_flag, timeout_flag, wdt_clear, halted;
   logic             osc_run, bad_operand;
   logic [7:0]       m_w, m_dir [5:7];   // Model W and direction registers
   logic             m_c, m_dc, m_z;     // Model flags
   int               failures = 0, tests_run = 0, cycles = 0;

   always #4 mclk = ~mclk;

   cxt_exec i_dut (.mclk, .nrst, .exec_valid, .exec_op, .file_addr, .dest_sel,
      .file_rdata, .imm_val, .wake, .wdt_ack(1'b0), .work_reg, .carry_flag,
      .digit_carry_flag, .zero_flag, .power_down_flag, .timeout_flag,
      .port_a_direction, .port_b_direction, .port_c_direction, .file_we,
      .file_waddr, .file_wdata, .wdt_clear, .watchdog_counter, .wdt_prescale,
      .halted, .osc_run, .bad_operand);

   task automatic chk(input string what, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One op, then W, flags, file write, direction registers and bad_operand against the model; ops are spaced by a
   // cycle so a held strobe can never run an op twice
   task automatic do_op(input cxt_tb_op_t op, input logic [6:0] a,
                        input logic d, input logic [7:0] f, k);
      logic [7:0] r;
      logic       b, fop, we, bad;
      b   = (op == op_subb) ? ~m_c : 1'b0;
      fop = op inside {op_sub, op_subb, op_swap, op_xf};
      we  = fop && d;
      bad = op == op_dir && !(a inside {7'h05, 7'h06, 7'h07});
      r   = (op == op_swap) ? {f[3:0], f[7:4]} : m_w ^ (op == op_xi ? k : f);
      if (op inside {op_sub, op_subb}) begin
         r    = f - m_w - {7'h00, b};
         m_c  = {1'b0, f} >= {1'b0, m_w} + {8'h00, b};
         m_dc = {1'b0, f[3:0]} >= {1'b0, m_w[3:0]} + {4'h0, b};
      end
      if (op inside {op_sub, op_subb, op_xi, op_xf}) m_z = (r == 8'h00);
      if (op == op_dir && !bad) m_dir[a] = m_w;
      if (op == op_xi || (fop && !d)) m_w = r;
      @(posedge mclk);
      exec_valid <= 1'b1;
      exec_op    <= op;
      file_addr  <= a;
      dest_sel   <= d;
      file_rdata <= f;
      imm_val    <= k;
      @(posedge mclk);
      exec_valid <= 1'b0;
      #1;
      chk("work", work_reg, m_w);
      chk("flags", {5'h00, carry_flag, digit_carry_flag, zero_flag},
          {5'h00, m_c, m_dc, m_z});
      chk("write", {7'h00, file_we}, {7'h00, we});
      if (we) chk("wdata", file_wdata, r);
      if (we) chk("waddr", {1'b0, file_waddr}, {1'b0, a});
      chk("dir_a", port_a_direction, m_dir[5]);
      chk("dir_b", port_b_direction, m_dir[6]);
      chk("dir_c", port_c_direction, m_dir[7]);
      chk("bad_op", {7'h00, bad_operand}, {7'h00, bad});
   endtask : do_op

   task automatic t_reset;
      #1;
      m_w   = 8'h00;
      m_c   = 1'b0;
      m_dc  = 1'b0;
      m_z   = 1'b0;
      m_dir = '{8'hFF, 8'hFF, 8'hFF};
      chk("rst_work", work_reg, 8'h00);
      chk("rst_stat", {carry_flag, digit_carry_flag, zero_flag, power_down_flag,
          timeout_flag, halted, osc_run, file_we}, 8'h1A);
      $display("test reset done");
   endtask : t_reset

   // Plain and borrow subtract with both destinations and borrow states
   task automatic t_arith;
      logic [7:0] fv [5] = '{8'h10, 8'hFF, 8'h0A, 8'h00, 8'h80};
      do_op(op_xi, 7'h00, 1'b0, 8'h00, 8'h03);
      do_op(op_sub, 7'h12, 1'b1, 8'h05, 8'h00);
      do_op(op_sub, 7'h7F, 1'b0, 8'h03, 8'h00);  // Zero result
      do_op(op_xi, 7'h00, 1'b0, 8'h00, 8'h05);
      do_op(op_sub, 7'h00, 1'b0, 8'h13, 8'h00);  // Low nibble borrow
      do_op(op_sub, 7'h01, 1'b0, 8'h02, 8'h00);  // Full borrow
      foreach (fv[i]) do_op(op_subb, 7'(i), i[0], fv[i], 8'h00);
      $display("test arith done");
   endtask : t_arith

   task automatic t_swap_xor;
      do_op(op_swap, 7'h20, 1'b0, 8'hA5, 8'h00);
      do_op(op_swap, 7'h21, 1'b1, 8'h3C, 8'h00);
      do_op(op_xf, 7'h22, 1'b1, 8'h5A, 8'h00);
      do_op(op_xf, 7'h23, 1'b0, m_w, 8'h00);     // Zero result
      do_op(op_xi, 7'h00, 1'b1, 8'h00, 8'hA5);   // Destination ignored
      $display("test swap_xor done");
   endtask : t_swap_xor

   // Operands 4 and 8 lie outside the valid range and must load nothing
   task automatic t_dir;
      for (int a = 4; a < 9; a++) begin
         do_op(op_xi, 7'h00, 1'b0, 8'h00, 8'(a) * 8'h13);
         do_op(op_dir, 7'(a), 1'b0, 8'h00, 8'h00);
      end
      $display("test dir done");
   endtask : t_dir

   task automatic t_sleep;
      repeat (300) @(posedge mclk);  // Let the watchdog count first
      do_op(cxt_pkg::cxt_op_sleep, 7'h00, 1'b0, 8'h00, 8'h00);
      chk("sleep", {3'h0, halted, osc_run, power_down_flag, timeout_flag,
          wdt_clear}, 8'h13);
      chk("wdt", watchdog_counter, 8'h00);
      chk("pre", wdt_prescale, 8'h00);
      @(posedge mclk);
      exec_valid <= 1'b1;
      exec_op    <= op_xi;
      imm_val    <= 8'hFF;
      @(posedge mclk);
      exec_valid <= 1'b0;
      wake       <= 1'b1;
      #1;
      chk("asleep", {6'h00, halted, osc_run}, 8'h02);
      chk("held_w", work_reg, m_w);
      // Wake seen: one restart cycle with the oscillator back, still halted
      @(posedge mclk);
      #1;
      chk("waking", {6'h00, halted, osc_run}, 8'h03);
      @(posedge mclk);
      wake <= 1'b0;
      #1;
      chk("woken", {6'h00, halted, osc_run}, 8'h01);
      do_op(op_xi, 7'h00, 1'b0, 8'h00, 8'h5A);
      $display("test sleep done");
   endtask : t_sleep

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   // Hang guard: the run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         test_done();
      end
   end

   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_arith();
      t_swap_xor();
      t_dir();
      t_sleep();
      test_done();
   end
endmodule : testbench
